// ===== scm_pkg.sv
// scm_pkg: constants for the shared address memory register bank.
// assumes a 32-bit avalon-mm slave with word-indexed registers.
package scm_pkg;

  // sizes of the bank
  localparam int ENTRY_COUNT = 32;
  localparam int PORT_COUNT = 13;
  localparam int ADDR_BYTES = 6;
  localparam int BUS_AW = 7;
  localparam int IDX_W = 5;

  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_PAGE = 5'h00;
  localparam logic [4:0] IDX_ENTRY = 5'h01;
  localparam logic [4:0] IDX_WINDOW = 5'h02;
  localparam logic [4:0] IDX_MASK_LO = 5'h03;
  localparam logic [4:0] IDX_MASK_HI = 5'h04;
  localparam logic [4:0] IDX_CTRL = 5'h05;
  localparam logic [4:0] IDX_VALID1 = 5'h16;
  localparam logic [4:0] IDX_VALID2 = 5'h17;
  localparam logic [4:0] IDX_VALID3 = 5'h18;
  localparam logic [4:0] IDX_VALID4 = 5'h19;

  // pages that open the shared entries
  localparam logic [3:0] PAGE_FIRST = 4'h9;
  localparam logic [3:0] PAGE_LAST = 4'hF;
  localparam logic [3:0] PAGE_VALID = 4'h9;

  // field positions
  localparam int MASK_HI_PTR_LSB = 5;
  localparam int CTRL_SEC_BIT = 0;

  // values after reset
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [4:0] ENTRY_RST = 5'h00;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [12:0] MASK_RST = 13'h0000;
  localparam logic [31:0] VALID_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ===== scm_addr_store.sv
// scm_addr_store: 48-bit address per entry behind a byte window.
// assumes access is a one-cycle commit strobe from the bus slave.
`timescale 1ns/100ps
module scm_addr_store #(
  parameter int ENTRIES = 32,
  parameter int BYTES = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // window access
  input wire logic [$clog2(ENTRIES)-1:0] sel,
  input wire logic access,
  input wire logic wr,
  input wire logic [7:0] wdata,
  // state of the selected entry
  output logic [7:0] rdata,
  output logic [2:0] ptr
);

  localparam logic [2:0] PTR_LAST = 3'(BYTES - 1);
  localparam int SELW = $clog2(ENTRIES);

  logic [BYTES-1:0][7:0] addr_reg [ENTRIES];
  logic [2:0] ptr_reg [ENTRIES];

  // pointer is three bits wide, so at most eight bytes
  if (BYTES < 1 || BYTES > 8 || ENTRIES < 2)
  begin : g_bad
    $error("scm_addr_store: unsupported size");
  end

  // one pointer and one byte array per entry
  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_ent
    wire hit = access && (sel == SELW'(i));
    wire [2:0] ptr_next = (ptr_reg[i] == PTR_LAST) ? scm_pkg::PTR_RST
                        : ptr_reg[i] + 3'h1;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ptr_reg[i] <= scm_pkg::PTR_RST;
        addr_reg[i] <= '0;
      end
      else if (hit)
      begin
        ptr_reg[i] <= ptr_next; // [RQ9]
        if (wr)
          addr_reg[i][ptr_reg[i]] <= wdata; // [RQ3] [RQ11]
      end
    end
  end

  // the window shows the byte the pointer selects
  assign ptr = ptr_reg[sel];
  assign rdata = addr_reg[sel][ptr_reg[sel]]; // [RQ2]

endmodule

// ===== scm_mask_store.sv
// scm_mask_store: port membership mask for every shared entry.
// assumes write strobes are one-cycle commits with byte lane 0 valid.
`timescale 1ns/100ps
module scm_mask_store #(
  parameter int ENTRIES = 32,
  parameter int PORTS = 13
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write side
  input wire logic [$clog2(ENTRIES)-1:0] sel,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  // read side
  output logic [7:0] lo_byte,
  output logic [PORTS-9:0] hi_bits
);

  localparam int SELW = $clog2(ENTRIES);

  logic [PORTS-1:0] mask_reg [ENTRIES];

  // high byte keeps three bits for the pointer
  if (PORTS < 9 || PORTS > 13)
  begin : g_bad
    $error("scm_mask_store: unsupported port count");
  end

  // each entry keeps its own mask, any subset of ports
  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_ent
    wire hit = (sel == SELW'(i));
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        mask_reg[i] <= scm_pkg::MASK_RST[PORTS-1:0];
      else if (hit && wr_lo)
        mask_reg[i][7:0] <= wdata; // [RQ6]
      else if (hit && wr_hi)
        mask_reg[i][PORTS-1:8] <= wdata[PORTS-9:0]; // [RQ7]
    end
  end

  assign lo_byte = mask_reg[sel][7:0];
  assign hi_bits = mask_reg[sel][PORTS-1:8];

endmodule

// ===== scm_bank.sv
// scm_bank: register bank of the shared address memory and masks.
// assumes an avalon-mm master with waitrequest on clk_sys; the
// comparison engine outside reads entry_compare_enable.
//
// Functional notes
// [RQ1] entries reachable only through pages 9h to fh
// [RQ2] six byte accesses load or fetch one address
// [RQ3] ascending bytes, first 7:0, sixth 47:40
// [RQ4] one membership mask per entry, 32 total
// [RQ5] entries and ports map many to many
// [RQ6] low mask byte bits flag ports one-eight
// [RQ7] high mask bits 0-4 flag ports nine-thirteen
// [RQ8] high mask bits 5-7 read-only byte pointer
// [RQ9] pointer advances per access, wraps after sixth
// [RQ10] only valid entries enabled once security starts
// [RQ11] second access carries address bits 15:8
`timescale 1ns/100ps
module scm_bank #(
  parameter int ENTRIES = scm_pkg::ENTRY_COUNT,
  parameter int PORTS = scm_pkg::PORT_COUNT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [scm_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // towards the comparison engine
  output logic security_active,
  output logic [ENTRIES-1:0] entry_compare_enable
);

  localparam int SW = $clog2(ENTRIES);

  // validity lives in four byte registers
  if (ENTRIES != 32 || PORTS != 13)
  begin : g_bad
    $error("scm_bank: bank is laid out for 32 entries, 13 ports");
  end

  // handshake and output registers
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic sec_out_reg;
  logic [ENTRIES-1:0] cmp_en_reg;
  logic [ENTRIES-1:0] cmp_en_next;

  // software state
  logic [3:0] page_reg;
  logic [SW-1:0] entry_reg;
  logic sec_reg;
  logic [ENTRIES-1:0] valid_reg;

  // request decode
  wire req = avs_read || avs_write;
  wire [scm_pkg::IDX_W-1:0] idx = avs_address[6:2];
  wire aligned = (avs_address[1:0] == 2'h0);
  wire lane0 = avs_byteenable[0];
  wire commit = req && !wait_reg;
  wire wr_commit = commit && avs_write && lane0;

  // page gating of the shared entry registers
  wire in_pages = (page_reg >= scm_pkg::PAGE_FIRST)
               && (page_reg <= scm_pkg::PAGE_LAST); // [RQ1]
  wire on_valid_page = (page_reg == scm_pkg::PAGE_VALID);

  // register hits
  wire hit_page = aligned && (idx == scm_pkg::IDX_PAGE);
  wire hit_ctrl = aligned && (idx == scm_pkg::IDX_CTRL);
  wire hit_entry = aligned && in_pages
                && (idx == scm_pkg::IDX_ENTRY); // [RQ1]
  wire hit_win = aligned && in_pages
              && (idx == scm_pkg::IDX_WINDOW); // [RQ1]
  wire hit_mlo = aligned && in_pages
              && (idx == scm_pkg::IDX_MASK_LO); // [RQ1]
  wire hit_mhi = aligned && in_pages
              && (idx == scm_pkg::IDX_MASK_HI); // [RQ1]
  wire hit_v1 = aligned && on_valid_page
             && (idx == scm_pkg::IDX_VALID1);
  wire hit_v2 = aligned && on_valid_page
             && (idx == scm_pkg::IDX_VALID2);
  wire hit_v3 = aligned && on_valid_page
             && (idx == scm_pkg::IDX_VALID3);
  wire hit_v4 = aligned && on_valid_page
             && (idx == scm_pkg::IDX_VALID4);

  // window accesses move the pointer on reads and on writes with byte lane 0 enabled
  wire win_access = commit && hit_win
                 && (avs_read || lane0); // [RQ9]
  wire win_wr = commit && hit_win && avs_write && lane0;

  // per-entry state from the two stores
  wire [7:0] win_byte;
  wire [2:0] win_ptr;
  wire [7:0] mask_lo;
  wire [PORTS-9:0] mask_hi;

  // high mask byte: pointer above the five port flags
  wire [7:0] mask_hi_word = {win_ptr, mask_hi}; // [RQ8]

  scm_addr_store #(
    .ENTRIES(ENTRIES),
    .BYTES(scm_pkg::ADDR_BYTES)
  ) u_addr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sel(entry_reg),
    .access(win_access),
    .wr(win_wr),
    .wdata(avs_writedata[7:0]),
    .rdata(win_byte),
    .ptr(win_ptr)
  );

  // mask writes never touch the pointer field
  scm_mask_store #(
    .ENTRIES(ENTRIES),
    .PORTS(PORTS)
  ) u_mask (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sel(entry_reg),
    .wr_lo(wr_commit && hit_mlo), // [RQ4] [RQ5]
    .wr_hi(wr_commit && hit_mhi), // [RQ8]
    .wdata(avs_writedata[7:0]),
    .lo_byte(mask_lo),
    .hi_bits(mask_hi)
  );

  // read multiplexer; unmapped or off-page indices read as zero
  always_comb
  begin
    rdata_next = scm_pkg::WORD_ZERO;
    if (hit_page)
      rdata_next[3:0] = page_reg;
    else if (hit_ctrl)
      rdata_next[scm_pkg::CTRL_SEC_BIT] = sec_reg;
    else if (hit_entry)
      rdata_next[SW-1:0] = entry_reg;
    else if (hit_win)
      rdata_next[7:0] = win_byte; // [RQ2]
    else if (hit_mlo)
      rdata_next[7:0] = mask_lo; // [RQ6]
    else if (hit_mhi)
      rdata_next[7:0] = mask_hi_word; // [RQ7] [RQ8]
    else if (hit_v1)
      rdata_next[7:0] = valid_reg[7:0];
    else if (hit_v2)
      rdata_next[7:0] = valid_reg[15:8];
    else if (hit_v3)
      rdata_next[7:0] = valid_reg[23:16];
    else if (hit_v4)
      rdata_next[7:0] = valid_reg[31:24];
  end

  // waitrequest drops for exactly one cycle per request
  assign wait_next = !(req && wait_reg);

  // read data is captured the edge before it is sampled, so the
  // window byte shown is the one addressed before the pointer moves
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= scm_pkg::WORD_ZERO;
    end
    else
    begin
      wait_reg <= wait_next;
      if (req && wait_reg && avs_read)
        rdata_reg <= rdata_next;
    end
  end

  // page select is global, so software can always leave a page
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      page_reg <= scm_pkg::PAGE_RST;
    else if (wr_commit && hit_page)
      page_reg <= avs_writedata[3:0];
  end

  // entry select picks which address and mask the window reaches
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      entry_reg <= scm_pkg::ENTRY_RST[SW-1:0];
    else if (wr_commit && hit_entry)
      entry_reg <= avs_writedata[SW-1:0]; // [RQ1]
  end

  // security start bit
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sec_reg <= 1'b0;
    else if (wr_commit && hit_ctrl)
      sec_reg <= avs_writedata[scm_pkg::CTRL_SEC_BIT];
  end

  // validity flags, one byte per register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      valid_reg <= scm_pkg::VALID_RST[ENTRIES-1:0];
    else if (wr_commit && hit_v1)
      valid_reg[7:0] <= avs_writedata[7:0];
    else if (wr_commit && hit_v2)
      valid_reg[15:8] <= avs_writedata[7:0];
    else if (wr_commit && hit_v3)
      valid_reg[23:16] <= avs_writedata[7:0];
    else if (wr_commit && hit_v4)
      valid_reg[31:24] <= avs_writedata[7:0];
  end

  // invalid entries stay out of comparison even while running
  assign cmp_en_next = sec_reg ? valid_reg
                     : scm_pkg::VALID_RST[ENTRIES-1:0]; // [RQ10]

  // registered outputs towards the comparison engine
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_out_reg <= 1'b0;
      cmp_en_reg <= scm_pkg::VALID_RST[ENTRIES-1:0];
    end
    else
    begin
      sec_out_reg <= sec_reg;
      cmp_en_reg <= cmp_en_next; // [RQ10]
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign security_active = sec_out_reg;
  assign entry_compare_enable = cmp_en_reg;

endmodule

// ===== scm_bank_properties.sv
// scm_bank_properties: bus timing and register checks for scm_bank.
// assumes it is bound to scm_bank and sees only that module's ports.
`timescale 1ns/100ps
module scm_bank_properties #(
  parameter int ENTRIES = 32,
  parameter int PORTS = 13
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [scm_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // towards the comparison engine
  input wire logic security_active,
  input wire logic [ENTRIES-1:0] entry_compare_enable
);
  logic [3:0] page_reg;
  logic [4:0] idx;
  logic page_wr;
  logic entry_reg_hit;

  // decode of the watched request
  assign idx = avs_address[6:2];
  assign page_wr = avs_write && !avs_waitrequest && avs_address == 7'h00
    && avs_byteenable[0];
  assign entry_reg_hit = idx >= scm_pkg::IDX_ENTRY
    && idx <= scm_pkg::IDX_MASK_HI;

  // page shadow, needed to know when entry registers are hidden
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      page_reg <= 4'h0;
    else if (page_wr)
      page_reg <= avs_writedata[3:0];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // steps of a transfer
  sequence s_req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd_commit;
    avs_read && !avs_waitrequest;
  endsequence
  sequence s_sec_on;
    avs_write && !avs_waitrequest && idx == scm_pkg::IDX_CTRL
      && avs_byteenable[0] && avs_writedata[0];
  endsequence

  chk_wait_one: assert property (
    s_req_seen |=> !avs_waitrequest) else $error("no answer after one wait");
  chk_wait_drop: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
  chk_rd_upper: assert property (
    avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  chk_off_page: assert property (
    s_rd_commit ##0 ((entry_reg_hit && page_reg < scm_pkg::PAGE_FIRST)
      || avs_address[1:0] != 2'b00) |-> avs_readdata == scm_pkg::WORD_ZERO)
    else $error("hidden register read not zero");
  chk_ptr_range: assert property (
    s_rd_commit ##0 (idx == scm_pkg::IDX_MASK_HI && page_reg >= 4'h9)
      |-> avs_readdata[7:5] <= 3'h5) else $error("byte pointer past five");
  chk_sec_follow: assert property (
    s_sec_on |-> ##2 security_active) else $error("security start lost");
  chk_enable_gate: assert property (
    !security_active |-> entry_compare_enable == {ENTRIES{1'b0}})
    else $error("entry enabled while security stopped");
  chk_rd_hold: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
endmodule

bind scm_bank scm_bank_properties #(.ENTRIES(ENTRIES), .PORTS(PORTS))
  i_scm_bank_properties (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .security_active(security_active),
  .entry_compare_enable(entry_compare_enable));

// ===== test_scm_bank.sv
// test_scm_bank: register sequences against the shared address bank.
// assumes scm_pkg and scm_bank are compiled first; one 100 mhz clock.
`timescale 1ns/100ps
module test_scm_bank;
  logic clk_sys;
  logic rst_n;
  logic [6:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic security_active;
  logic [31:0] entry_compare_enable;
  logic [7:0] rd;
  logic [47:0] mac;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  // device under test
  scm_bank #(.ENTRIES(32), .PORTS(13)) i_scm_bank (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .security_active(security_active),
    .entry_compare_enable(entry_compare_enable));

  // 100 mhz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ceiling far above the roughly 800 cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [6:0] adr,
    input logic [3:0] be, input logic [7:0] wd, output logic [7:0] q);
    avs_address <= adr;
    avs_read <= !we;
    avs_write <= we;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] wd);
    logic [7:0] q;
    bus(1'b1, {idx, 2'b00}, 4'h1, wd, q);
  endtask

  task automatic rdc(input logic [4:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, {idx, 2'b00}, 4'h1, 8'h00, q);
    check({24'h00_0000, q}, {24'h00_0000, exp});
  endtask

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    mac = 48'hA1B2_C3D4_E5F6;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // reset page hides the entry registers
    rdc(scm_pkg::IDX_WINDOW, 8'h00);
    rdc(scm_pkg::IDX_MASK_HI, 8'h00);
    // load one address, pointer seen in the mask high byte
    wr(scm_pkg::IDX_PAGE, 8'h09);
    wr(scm_pkg::IDX_ENTRY, 8'h03);
    rdc(scm_pkg::IDX_PAGE, 8'h09);
    rdc(scm_pkg::IDX_ENTRY, 8'h03);
    for (int n = 0; n < 6; n++)
    begin
      wr(scm_pkg::IDX_WINDOW, mac[8*n +: 8]);
      rdc(scm_pkg::IDX_MASK_HI, {3'((n + 1) % 6), 5'h00});
    end
    // fetch back in ascending byte order
    for (int n = 0; n < 6; n++)
      rdc(scm_pkg::IDX_WINDOW, mac[8*n +: 8]);
    rdc(scm_pkg::IDX_MASK_HI, 8'h00);
    // a mask per entry, written across all seven shared pages
    for (int e = 0; e < 32; e++)
    begin
      wr(scm_pkg::IDX_PAGE, 8'(9 + e % 7));
      wr(scm_pkg::IDX_ENTRY, 8'(e));
      wr(scm_pkg::IDX_MASK_LO, 8'(e * 7 + 1));
      wr(scm_pkg::IDX_MASK_HI, 8'(8'hE0 | e));
    end
    wr(scm_pkg::IDX_PAGE, 8'h0F);
    for (int e = 0; e < 32; e++)
    begin
      wr(scm_pkg::IDX_ENTRY, 8'(e));
      rdc(scm_pkg::IDX_MASK_LO, 8'(e * 7 + 1));
      rdc(scm_pkg::IDX_MASK_HI, 8'(e));
    end
    // off the shared pages, bad lanes and misaligned addresses
    wr(scm_pkg::IDX_PAGE, 8'h08);
    wr(scm_pkg::IDX_MASK_LO, 8'h00);
    rdc(scm_pkg::IDX_MASK_LO, 8'h00);
    wr(scm_pkg::IDX_PAGE, 8'h0A);
    bus(1'b1, {scm_pkg::IDX_MASK_LO, 2'b00}, 4'h0, 8'h00, rd);
    rdc(scm_pkg::IDX_MASK_LO, 8'(31 * 7 + 1));
    bus(1'b0, 7'h0D, 4'h1, 8'h00, rd);
    check({24'h00_0000, rd}, 32'h0000_0000);
    // validity counts only once security starts
    wr(scm_pkg::IDX_PAGE, 8'h09);
    wr(scm_pkg::IDX_VALID1, 8'h05);
    wr(scm_pkg::IDX_VALID4, 8'h80);
    rdc(scm_pkg::IDX_VALID1, 8'h05);
    rdc(scm_pkg::IDX_VALID4, 8'h80);
    check(entry_compare_enable, 32'h0000_0000);
    wr(scm_pkg::IDX_CTRL, 8'h01);
    rdc(scm_pkg::IDX_CTRL, 8'h01);
    repeat (2) @(posedge clk_sys);
    check(32'(security_active), 32'h0000_0001);
    check(entry_compare_enable, 32'h8000_0005);
    wr(scm_pkg::IDX_CTRL, 8'h00);
    repeat (2) @(posedge clk_sys);
    check(32'(security_active), 32'h0000_0000);
    check(entry_compare_enable, 32'h0000_0000);
    close_out();
  end
endmodule
